// ### pkg/fsf_map.svh
// Constants for the status-word flag logic: bit positions, codes, resets
`ifndef FSF_MAP_SVH
`define FSF_MAP_SVH
`define FSF_SW_RESET 16'h0000
`define FSF_CW_RESET 16'h037F
`define FSF_BIT_INVALID 3'h0
`define FSF_BIT_SUBNORM 3'h1
`define FSF_BIT_DIVNIL 3'h2
`define FSF_BIT_OVERFLOW 3'h3
`define FSF_BIT_UNDERFLOW 3'h4
`define FSF_BIT_INEXACT 3'h5
`define FSF_POS_FAULT 4'h6
`define FSF_POS_SUMMARY 4'h7
`define FSF_POS_COND0 4'h8
`define FSF_POS_COND1 4'h9
`define FSF_POS_COND2 4'hA
`define FSF_POS_COND3 4'hE
`define FSF_POS_BUSY 4'hF
`define FSF_EXC_NONE 6'h00
`define FSF_TRIG_EXP 16'h403E
`endif

// ### pkg/fsf_pkg.sv
// Types shared by the status-word flag logic
package fsf_pkg;
	typedef enum logic [3:0] {
		FSF_CLS_ARITH = 4'h0,
		FSF_CLS_COMPARE = 4'h1,
		FSF_CLS_COMPARE_INT = 4'h2,
		FSF_CLS_CLASSIFY = 4'h3,
		FSF_CLS_REMAINDER = 4'h4,
		FSF_CLS_TRIG = 4'h5,
		FSF_CLS_MOVE = 4'h6,
		FSF_CLS_LOAD_ENV = 4'h7,
		FSF_CLS_CLEAR_EXC = 4'h8,
		FSF_CLS_INIT = 4'h9,
		FSF_CLS_OTHER = 4'hA
	} fsf_class_t;
	// One completing instruction with its results
	typedef struct packed {
		fsf_class_t cls;
		logic [5:0] exc;
		logic stack_fault;
		logic stack_over;
		logic round_up;
		logic [2:0] cmp_code;
		logic [3:0] class_code;
		logic sign;
		logic reduce_incomplete;
		logic [2:0] quotient;
		logic [14:0] src_exp;
		logic [15:0] mem_image;
	} fsf_done_t;
endpackage

// ### verilog/fsf_sticky_bit.sv
// One sticky flag with set-over-clear and a memory load path
`timescale 1ns/100ps
`default_nettype none
module fsf_sticky_bit (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Controls
	input wire logic set_in,
	input wire logic clear_in,
	input wire logic load_in,
	input wire logic load_val_in,
	// State
	output logic flag_out
);
	logic flag_r;
	// Load wins, then set, then clear, so a clear never drops a set
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flag_r <= 1'b0;
		end else if (load_in) begin
			flag_r <= load_val_in;
		end else if (set_in) begin
			flag_r <= 1'b1;
		end else if (clear_in) begin
			flag_r <= 1'b0;
		end
	end
	assign flag_out = flag_r;
endmodule
`default_nettype wire

// ### verilog/fsf_status_flags.sv
// Status-word condition, exception, stack-fault and summary logic
`timescale 1ns/100ps
`default_nettype none
`include "fsf_map.svh"
module fsf_status_flags (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Completing instruction
	input wire logic done_valid_in,
	input wire fsf_pkg::fsf_done_t done_in,
	// Control word (mask bits in 5:0)
	input wire logic [15:0] ctrl_word_in,
	// Status view
	output logic [15:0] status_word_out,
	output logic handler_req_out
);
	import fsf_pkg::*;

	logic [3:0] cc_r;
	logic [3:0] cc_nxt;
	logic [5:0] exc_flags;
	logic fault_flag;
	logic summary_bit;
	logic [5:0] unmasked;
	logic clr_all;
	logic load_mem;
	logic trig_out_range;
	logic fault_c1;
	logic c1_flag_view;
	logic [15:0] img;

	assign img = done_in.mem_image;

	// Clearing classes; save shares the init encoding
	assign clr_all = done_valid_in &&
		(done_in.cls == FSF_CLS_CLEAR_EXC || done_in.cls == FSF_CLS_INIT);
	assign load_mem = done_valid_in && done_in.cls == FSF_CLS_LOAD_ENV;

	// sticky exception flags, one instance per bit
	// clear only by clear, init or memory load
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_exc
			fsf_sticky_bit u_flag (
				.clk_sys_in(clk_sys_in),
				.rstn_in(rstn_in),
				.set_in(done_valid_in && done_in.exc[gi]),
				.clear_in(clr_all),
				.load_in(load_mem),
				.load_val_in(img[gi]),
				.flag_out(exc_flags[gi])
			);
		end
	endgenerate

	// stack fault set on overflow or underflow
	// sticky, only init, clear, save or memory load drop it
	fsf_sticky_bit u_stack_fault (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.set_in(done_valid_in && done_in.stack_fault),
		.clear_in(clr_all),
		.load_in(load_mem),
		.load_val_in(img[`FSF_POS_FAULT]),
		.flag_out(fault_flag)
	);

	// Exponent above bias plus 63 means magnitude at or past two to 64
	assign trig_out_range = done_in.src_exp >= 15'(`FSF_TRIG_EXP + 16'h0001);

	// Bit one on a stack fault names the direction, else round-up
	assign fault_c1 = done_in.stack_over;

	// Next condition bits per class; undefined ones are held
	always_comb begin
		cc_nxt = cc_r;
		c1_flag_view = 1'b0;
		case (done_in.cls)
			// compare result in 0,2,3; bit one zero or fault
			FSF_CLS_COMPARE: begin
				cc_nxt[0] = done_in.cmp_code[0];
				cc_nxt[2] = done_in.cmp_code[1];
				cc_nxt[3] = done_in.cmp_code[2];
				cc_nxt[1] = done_in.stack_fault ? fault_c1 : 1'b0;
			end
			// only stack fault reported in bit one
			FSF_CLS_COMPARE_INT: begin
				cc_nxt[1] = done_in.stack_fault ? fault_c1 : 1'b0;
			end
			FSF_CLS_CLASSIFY: begin
				cc_nxt[1] = done_in.sign;
				cc_nxt[0] = done_in.class_code[0];
				cc_nxt[2] = done_in.class_code[1];
				cc_nxt[3] = done_in.class_code[2];
			end
			FSF_CLS_REMAINDER: begin
				cc_nxt[2] = done_in.reduce_incomplete;
				if (!done_in.reduce_incomplete) begin
					cc_nxt[0] = done_in.quotient[2];
					cc_nxt[3] = done_in.quotient[1];
					cc_nxt[1] = done_in.quotient[0];
				end
				// A fault takes bit one, the quotient keeps 0 and 3
				if (done_in.stack_fault) begin
					cc_nxt[1] = fault_c1;
				end
			end
			// range check of the source operand
			FSF_CLS_TRIG: begin
				cc_nxt[2] = trig_out_range;
				if (done_in.stack_fault) begin
					cc_nxt[1] = fault_c1;
				end else if (!trig_out_range) begin
					cc_nxt[1] = done_in.exc[`FSF_BIT_INEXACT] &&
						done_in.round_up;
				end
			end
			FSF_CLS_ARITH: begin
				if (done_in.stack_fault) begin
					cc_nxt[1] = fault_c1;
				end else begin
					cc_nxt[1] = done_in.exc[`FSF_BIT_INEXACT] &&
						done_in.round_up;
				end
			end
			// bit one zero unless a stack fault
			FSF_CLS_MOVE: begin
				cc_nxt[1] = done_in.stack_fault ? fault_c1 : 1'b0;
			end
			// every condition bit from the image
			FSF_CLS_LOAD_ENV: begin
				cc_nxt[0] = img[`FSF_POS_COND0];
				cc_nxt[1] = img[`FSF_POS_COND1];
				cc_nxt[2] = img[`FSF_POS_COND2];
				cc_nxt[3] = img[`FSF_POS_COND3];
			end
			FSF_CLS_INIT: begin
				cc_nxt = 4'h0;
			end
			default: begin
				cc_nxt = cc_r;
			end
		endcase
		// overflow high, underflow low when invalid and fault
		if (done_in.stack_fault && done_in.exc[`FSF_BIT_INVALID]) begin
			c1_flag_view = 1'b1;
			cc_nxt[1] = done_in.stack_over;
		end
	end

	// condition bits commit with the flags at completion
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cc_r <= 4'h0;
		end else if (done_valid_in) begin
			cc_r <= cc_nxt;
		end
	end

	// control mask bits block summary contribution
	// masked flags still stick but do not raise summary
	assign unmasked = exc_flags & ~ctrl_word_in[5:0];
	assign summary_bit = unmasked != `FSF_EXC_NONE;
	assign handler_req_out = summary_bit;

	// Word assembly; top-of-stack field lives elsewhere and reads zero
	always_comb begin
		status_word_out = `FSF_SW_RESET;
		status_word_out[5:0] = exc_flags;
		status_word_out[`FSF_POS_FAULT] = fault_flag;
		status_word_out[`FSF_POS_SUMMARY] = summary_bit;
		status_word_out[`FSF_POS_COND0] = cc_r[0];
		status_word_out[`FSF_POS_COND1] = cc_r[1];
		status_word_out[`FSF_POS_COND2] = cc_r[2];
		status_word_out[`FSF_POS_COND3] = cc_r[3];
		status_word_out[`FSF_POS_BUSY] = summary_bit;
	end

	// Checks
	property mirror_p;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		status_word_out[15] == status_word_out[7];
	endproperty
	mirror_bit_a: assert property (mirror_p)
		else $error("mirror bit differs from summary");

	summary_any_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		((status_word_out[5:0] & ~ctrl_word_in[5:0]) != 6'h00)
		|-> status_word_out[7])
		else $error("summary missing for unmasked flag");

	masked_quiet_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		((status_word_out[5:0] & ~ctrl_word_in[5:0]) == 6'h00)
		|-> !handler_req_out)
		else $error("summary raised by masked flag");

	sequence exc_done_s;
		done_valid_in && done_in.exc[0] && done_in.cls != FSF_CLS_LOAD_ENV;
	endsequence
	exc_sticky_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		exc_done_s |=> status_word_out[0])
		else $error("invalid flag not set");

	hold_flags_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!done_valid_in |=> $stable(status_word_out[6:0]))
		else $error("flags changed without instruction");

	fault_stick_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		status_word_out[6] && !(done_valid_in &&
		(done_in.cls == FSF_CLS_CLEAR_EXC || done_in.cls == FSF_CLS_INIT ||
		done_in.cls == FSF_CLS_LOAD_ENV)) |=> status_word_out[6])
		else $error("stack fault dropped");

	direction_c1_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		done_valid_in && done_in.stack_fault && done_in.exc[0]
		&& c1_flag_view |=> status_word_out[9] == $past(done_in.stack_over))
		else $error("bit one not fault direction");

	sequence rem_done_s;
		done_valid_in && done_in.cls == FSF_CLS_REMAINDER &&
		!done_in.reduce_incomplete && !done_in.stack_fault;
	endsequence
	quot_load_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		rem_done_s |=> status_word_out[8] == $past(done_in.quotient[2])
		&& status_word_out[14] == $past(done_in.quotient[1])
		&& !status_word_out[10])
		else $error("quotient bits misplaced");

	trig_range_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		done_valid_in && done_in.cls == FSF_CLS_TRIG
		|=> status_word_out[10] == $past(trig_out_range))
		else $error("range bit wrong");

	init_clear_a: assert property (
		@(posedge clk_sys_in) disable iff (!rstn_in)
		done_valid_in && done_in.cls == FSF_CLS_INIT
		|=> status_word_out == 16'h0000)
		else $error("init did not clear word");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the status-word flag logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import fsf_pkg::*;
	logic clk_sys_in;
	logic rstn_in;
	logic done_valid_in;
	fsf_done_t done_in;
	logic [15:0] ctrl_word_in;
	logic [15:0] status_word_out;
	logic handler_req_out;
	int bad_count;
	int comparisons;
	int seed;
	logic run;
	logic [5:0] m_flags;
	logic m_fault;
	logic m_sum;
	logic [3:0] m_cc;
	logic [15:0] exp_sw;
	logic [63:0] r;
	fsf_done_t d;

	fsf_status_flags u_dut (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.done_valid_in(done_valid_in),
		.done_in(done_in),
		.ctrl_word_in(ctrl_word_in),
		.status_word_out(status_word_out),
		.handler_req_out(handler_req_out)
	);

	// Free-running 250 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task model_clear;
		{m_flags, m_fault, m_cc} = '0;
	endtask

	// undefined condition bits are never relied on; model holds them
	task model_step(input fsf_done_t i);
		case (i.cls)
			FSF_CLS_ARITH: m_cc[1] = i.exc[5] & i.round_up;
			FSF_CLS_COMPARE: {m_cc[3], m_cc[2], m_cc[0], m_cc[1]} = {i.cmp_code, 1'b0};
			FSF_CLS_COMPARE_INT, FSF_CLS_MOVE: m_cc[1] = 1'b0;
			FSF_CLS_CLASSIFY: {m_cc[3], m_cc[2], m_cc[0], m_cc[1]} = {i.class_code[2:0], i.sign};
			FSF_CLS_REMAINDER: begin
				m_cc[2] = i.reduce_incomplete;
				if (!m_cc[2]) {m_cc[0], m_cc[3], m_cc[1]} = i.quotient;
			end
			FSF_CLS_TRIG: begin
				m_cc[2] = i.src_exp >= 15'h403F;
				if (!m_cc[2]) m_cc[1] = i.exc[5] & i.round_up;
			end
			FSF_CLS_LOAD_ENV: begin
				{m_fault, m_flags} = i.mem_image[6:0];
				m_cc = {i.mem_image[14], i.mem_image[10:8]};
			end
			FSF_CLS_CLEAR_EXC: {m_flags, m_fault} = '0;
			FSF_CLS_INIT: model_clear();
			default: ;
		endcase
		m_flags = m_flags | i.exc;
		m_fault = m_fault | i.stack_fault;
		if (i.exc[0] & i.stack_fault) m_cc[1] = i.stack_over;
	endtask

	// Model first, then launch the next random instruction
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			model_clear();
		end else if (done_valid_in) begin
			model_step(done_in);
		end
		r = {$random(seed), $random(seed)};
		d = r[55:0];
		d.cls = fsf_class_t'(4'($unsigned($random(seed)) % 11));
		d.exc = d.exc & r[61:56];
		d.stack_fault = r[62] & r[63] & r[56];
		if (d.stack_fault) d.exc[0] = 1'b1;
		if (r[57]) d.src_exp = 15'h403E + 15'(r[58]);
		// Pending fault is cleared before ordinary traffic resumes
		if (m_flags[0] & m_fault) begin
			d.cls = r[59] ? FSF_CLS_CLEAR_EXC : FSF_CLS_INIT;
		end
		if (d.cls inside {FSF_CLS_LOAD_ENV, FSF_CLS_CLEAR_EXC, FSF_CLS_INIT}) begin
			d.exc = 6'h00;
			d.stack_fault = 1'b0;
		end
		done_in <= d;
		done_valid_in <= run & (r[60] | r[61]);
		if (run && ($random(seed) & 7) == 0) begin
			ctrl_word_in <= 16'($random(seed));
		end
	end

	// Compare every settled cycle, reset included
	always @(negedge clk_sys_in) begin
		m_sum = |(m_flags & ~ctrl_word_in[5:0]);
		exp_sw = {m_sum, m_cc[3], 3'h0, m_cc[2:0], m_sum, m_fault, m_flags};
		check(status_word_out & 16'h00FF, exp_sw & 16'h00FF);
		check(status_word_out & 16'h7F00, exp_sw & 16'h7F00);
		check({15'h0, status_word_out[15]}, {15'h0, m_sum});
		check({15'h0, handler_req_out}, {15'h0, m_sum});
	end

	// Main sequence with a reset in mid-run
	initial begin
		seed = 32'hb7b4;
		bad_count = 0;
		comparisons = 0;
		run = 1'b0;
		rstn_in = 1'b0;
		done_valid_in = 1'b0;
		done_in = '0;
		ctrl_word_in = 16'h037F;
		model_clear();
		repeat (2) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		@(negedge clk_sys_in);
		run = 1'b1;
		repeat (3000) @(negedge clk_sys_in);
		run = 1'b0;
		// Let the last launched instruction retire before reset
		repeat (2) @(posedge clk_sys_in);
		rstn_in <= 1'b0;
		model_clear();
		repeat (2) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		@(negedge clk_sys_in);
		run = 1'b1;
		repeat (2000) @(negedge clk_sys_in);
		finish_test();
	end

	// Hang guard, well beyond the planned run
	initial begin
		#(4 * 12000);
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
